// [prp_pkg.sv]
// Package: constants shared by the position pulse reference front end
package prp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0]  CTRL_OFS = 8'h00;   // Form, multiplier, filter, smoothing
    localparam logic [7:0]  NUM_OFS  = 8'h04;   // Gear numerator
    localparam logic [7:0]  DEN_OFS  = 8'h08;   // Gear denominator
    localparam logic [7:0]  ERR_OFS  = 8'h0C;   // Position error counter, read only
    localparam logic [7:0]  STAT_OFS = 8'h10;   // Clear and loop state, read only

    // ------------------------------------------------------------
    // Control field layout and encodings
    // ------------------------------------------------------------
    localparam int unsigned FORM_LSB   = 0;
    localparam int unsigned MULT_LSB   = 2;
    localparam int unsigned OCF_BIT    = 4;
    localparam int unsigned SMOOTH_BIT = 5;
    localparam int unsigned CTRL_W     = 6;
    localparam logic [1:0]  FORM_STEP  = 2'h0;  // Step plus direction
    localparam logic [1:0]  FORM_DUAL  = 2'h1;  // Forward and reverse pulses
    localparam logic [1:0]  FORM_QUAD  = 2'h2;  // Two phase quadrature
    localparam logic [1:0]  MULT_X1    = 2'h0;
    localparam logic [1:0]  MULT_X2    = 2'h1;
    localparam logic [1:0]  MULT_X4    = 2'h2;
    localparam int unsigned STAT_CLR_BIT  = 0;
    localparam int unsigned STAT_LOOP_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0]  CTRL_RST = 6'h00;
    localparam logic [15:0] NUM_RST  = 16'h0001;
    localparam logic [15:0] DEN_RST  = 16'h0001;

    // ------------------------------------------------------------
    // Timing: clock rate, input filter times, rated pulse rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 10;
    localparam int unsigned FILT_NORM_NS   = 200;
    localparam int unsigned FILT_OC_NS     = 800;
    localparam int unsigned LEN_W          = 4;
    localparam int unsigned RATE_LD_KPPS   = 500;
    localparam int unsigned RATE_OC_KPPS   = 200;
    localparam int unsigned RATE_X2_KPPS   = 400;
    localparam int unsigned RATE_X4_KPPS   = 200;
    // Filter lengths round down so they never swallow a legal pulse
    localparam int unsigned FILT_NORM_CYC  = (FILT_NORM_NS * CLK_MHZ / 1000 < 1) ? 1
                                           : FILT_NORM_NS * CLK_MHZ / 1000;
    localparam int unsigned FILT_OC_CYC    = (FILT_OC_NS * CLK_MHZ / 1000 < 1) ? 1
                                           : FILT_OC_NS * CLK_MHZ / 1000;

endpackage

// [prp_in_filter.sv]
// Module: two-flop synchroniser followed by a stable-level input filter
module prp_in_filter #(
    parameter int unsigned LEN_W     = 4,
    parameter logic        RST_LEVEL = 1'b0
) (
    input  wire logic             i_sys_clk,  // System clock
    input  wire logic             i_rst_n,    // Async reset, active low
    input  wire logic             i_pin,      // Raw pin level
    input  wire logic [LEN_W-1:0] i_len,      // Cycles the level must hold
    output logic                  o_level     // Filtered level
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (LEN_W < 1) begin : g_bad_len
        $error("prp_in_filter: LEN_W must be at least 1");
    end

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             level;
        logic [LEN_W-1:0] cnt;
    } prp_filt_type;

    prp_filt_type q;
    prp_filt_type next_q;

    // Synchronise first; only the second flop feeds the filter
    always_comb begin
        next_q       = q;
        next_q.sync1 = i_pin;
        next_q.sync2 = q.sync1;
        if (q.sync2 == q.level) begin
            next_q.cnt = '0;
        end else if (q.cnt >= i_len - LEN_W'(1)) begin
            next_q.level = q.sync2;
            next_q.cnt   = '0;
        end else begin
            next_q.cnt = q.cnt + LEN_W'(1);
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{sync1: RST_LEVEL, sync2: RST_LEVEL, level: RST_LEVEL, cnt: '0};
        end else begin
            q <= next_q;
        end
    end

    assign o_level = q.level;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // RULE15: two flop delay
    a_sync_two_flop: assert property ($changed(q.sync2) |-> q.sync2 == $past(i_pin, 2)) // RULE15
        else $error("synchroniser stage skipped");

    // RULE8: filter hold time
    a_filter_hold_len: assert property ($changed(q.level) |-> $past(q.cnt) >= $past(i_len) - LEN_W'(1)) // RULE8
        else $error("filtered level changed before hold time");

endmodule

// [prp_pulse_ref.sv]
// Module: pulse-train position reference decoder with electronic gear and error counter
//
// Added by the designer: the address-and-strobe port and the register offsets.

// Summary of operation
// RULE1: Step form counts forward while direction is high, reverse while low.
// RULE2: Step form takes 500 kpps line driver, host keeps open collector at 200 kpps.
// RULE3: Dual form counts forward channel forward and reverse channel reverse.
// RULE4: Quadrature is forward when phase B leads A, reverse when it lags.
// RULE5: Quadrature multiplier x1, x2 or x4, rated 500, 400 and 200 kpps.
// RULE6: Host waits over 40 ms after servo on before sending pulses; the bench starts pulses right after t_regs.
// RULE7: Host holds clear asserted longer than 200 us.
// RULE8: Open collector filter bit set applies longer input filtering.
// RULE9: Counted pulses are scaled by gear numerator over denominator.
// RULE10: Software reduces numerator and denominator by a common factor when out of range.
// RULE11: Smoothing select zero picks first filter, one picks second.
// RULE12: Clear zeroes the error counter and disables the position loop.
// RULE13: Software keeps the gear ratio between one hundredth and one hundred.
// RULE14: Gear remainder carries forward so no counts are lost.
// RULE15: All reference inputs are synchronised before edge detection.
module prp_pulse_ref #(
    parameter int unsigned ERR_W = 32,
    parameter int unsigned RES_W = 40
) (
    input  wire logic                      i_sys_clk,      // System clock, 10 MHz
    input  wire logic                      i_rst_n,        // Async reset, active low
    input  wire logic                      i_ref_pulse,    // Reference pulse input / phase A / forward
    input  wire logic                      i_ref_sign,     // Sign input / phase B / reverse
    input  wire logic                      i_clear_req_n,  // Clear request input, active low
    input  wire logic                      i_fb_step,      // Feedback count strobe, same clock
    input  wire logic                      i_fb_dir,       // Feedback direction, 1 forward
    input  wire logic [prp_pkg::ADDR_W-1:0] i_addr,        // Register address
    input  wire logic [31:0]               i_wdata,        // Register write data
    input  wire logic                      i_wr,           // Write strobe
    input  wire logic                      i_rd,           // Read strobe
    output logic      [31:0]               o_rdata,        // Read data, one cycle after strobe
    output logic signed [ERR_W-1:0]        o_err_count,    // Position error counter
    output logic                           o_loop_enable,  // Position loop enabled
    output logic                           o_smooth_sel,   // 0 first filter, 1 second filter
    output logic                           o_clear_active  // Clear request recognised
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ERR_W < 16 || ERR_W > 32 || RES_W < 24 + 16) begin : g_bad_width
        $error("prp_pulse_ref: ERR_W must be 16..32 and RES_W at least 40");
    end
    // RULE2: rated rates must fit the filters
    if (prp_pkg::FILT_OC_CYC * prp_pkg::RATE_OC_KPPS * 4 >= prp_pkg::CLK_MHZ * 1000) begin : g_bad_oc
        $error("prp_pulse_ref: open collector filter too long for rated input");
    end
    if (prp_pkg::FILT_NORM_CYC * prp_pkg::RATE_LD_KPPS * 4 >= prp_pkg::CLK_MHZ * 1000) begin : g_bad_ld
        $error("prp_pulse_ref: line driver filter too long for rated input");
    end
    if (prp_pkg::FILT_NORM_CYC * prp_pkg::RATE_X4_KPPS * 8 >= prp_pkg::CLK_MHZ * 1000
        || prp_pkg::FILT_NORM_CYC * prp_pkg::RATE_X2_KPPS * 4 >= prp_pkg::CLK_MHZ * 1000) begin : g_bad_quad
        $error("prp_pulse_ref: filter too long for quadrature edge spacing");
    end

    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]              form;
        logic [1:0]              mult;
        logic                    ocf;
        logic                    smooth;
        logic [15:0]             num;
        logic [15:0]             den;
        logic                    p_d;
        logic                    s_d;
        logic signed [1:0]       delta;
        logic signed [RES_W-1:0] resid;
        logic signed [ERR_W-1:0] err;
        logic                    clr;
        logic                    loop_en;
        logic [31:0]             rdata;
    } prp_state_type;

    prp_state_type q;
    prp_state_type next_q;

    logic                      p_filt;
    logic                      s_filt;
    logic                      clr_filt_n;
    logic [prp_pkg::LEN_W-1:0] filt_len;

    // Largest shift s (0..7) with den << s not above mag; bounded work per cycle
    function automatic logic [2:0] prp_shift(input logic [RES_W-1:0] mag, input logic [15:0] den);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (((RES_W'(den)) << i) <= mag) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    // RULE8: longer open collector filter
    assign filt_len = q.ocf ? prp_pkg::LEN_W'(prp_pkg::FILT_OC_CYC)
                            : prp_pkg::LEN_W'(prp_pkg::FILT_NORM_CYC);

    // RULE15: synchronise every reference pin
    prp_in_filter #(.LEN_W(prp_pkg::LEN_W), .RST_LEVEL(1'b0)) u_filt_pulse (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_ref_pulse),
        .i_len     (filt_len),
        .o_level   (p_filt)
    );
    prp_in_filter #(.LEN_W(prp_pkg::LEN_W), .RST_LEVEL(1'b0)) u_filt_sign (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_ref_sign),
        .i_len     (filt_len),
        .o_level   (s_filt)
    );
    // Clear is slow, so it always takes the long filter
    prp_in_filter #(.LEN_W(prp_pkg::LEN_W), .RST_LEVEL(1'b1)) u_filt_clear (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_clear_req_n),
        .i_len     (prp_pkg::LEN_W'(prp_pkg::FILT_OC_CYC)),
        .o_level   (clr_filt_n)
    );

    // ------------------------------------------------------------
    // Next state: decode, gear, error counter, registers
    // ------------------------------------------------------------
    always_comb begin
        logic                    p_rise;
        logic                    s_rise;
        logic                    p_edge;
        logic                    s_edge;
        logic signed [1:0]       d;
        logic signed [RES_W-1:0] r;
        logic signed [RES_W-1:0] den_w;
        logic signed [ERR_W-1:0] e;
        logic [2:0]              sh;
        p_rise = p_filt & ~q.p_d;
        s_rise = s_filt & ~q.s_d;
        p_edge = p_filt ^ q.p_d;
        s_edge = s_filt ^ q.s_d;
        d      = 2'sd0;
        r      = q.resid;
        den_w  = RES_W'(q.den);
        e      = q.err;
        sh     = 3'h0;
        next_q = q;
        next_q.p_d = p_filt;
        next_q.s_d = s_filt;

        // Pulse form decode
        case (q.form)
            prp_pkg::FORM_STEP: begin
                // RULE1: direction by sign level
                if (p_rise) begin
                    d = s_filt ? 2'sd1 : -2'sd1;
                end
            end
            prp_pkg::FORM_DUAL: begin
                // RULE3: separate channels, coincident edges cancel
                if (p_rise && !s_rise) begin
                    d = 2'sd1;
                end else if (s_rise && !p_rise) begin
                    d = -2'sd1;
                end
            end
            prp_pkg::FORM_QUAD: begin
                // RULE4: B leads A is forward
                // RULE5: multiplier picks counted edges
                case (q.mult)
                    prp_pkg::MULT_X1: begin
                        if (p_rise) begin
                            d = s_filt ? 2'sd1 : -2'sd1;
                        end
                    end
                    prp_pkg::MULT_X2: begin
                        if (p_edge) begin
                            d = (p_filt == s_filt) ? 2'sd1 : -2'sd1;
                        end
                    end
                    default: begin
                        if (p_edge && !s_edge) begin
                            d = (p_filt == s_filt) ? 2'sd1 : -2'sd1;
                        end else if (s_edge && !p_edge) begin
                            d = (s_filt != p_filt) ? 2'sd1 : -2'sd1;
                        end
                    end
                endcase
            end
            default: d = 2'sd0;
        endcase
        next_q.delta = d;

        // RULE9: add numerator per counted pulse
        if (q.delta == 2'sd1) begin
            r = r + RES_W'(q.num);
        end else if (q.delta == -2'sd1) begin
            r = r - RES_W'(q.num);
        end
        // RULE14: keep remainder, emit whole counts
        if (r[RES_W-1]) begin
            sh = prp_shift(RES_W'(-r), q.den);
            r  = r + (den_w <<< sh);
            e  = e - ERR_W'(32'h1 << sh);
        end else if (r >= den_w) begin
            sh = prp_shift(RES_W'(r), q.den);
            r  = r - (den_w <<< sh);
            e  = e + ERR_W'(32'h1 << sh);
        end
        if (i_fb_step) begin
            e = i_fb_dir ? e - ERR_W'(1) : e + ERR_W'(1);
        end

        // RULE12: clear zeroes counter, opens loop
        next_q.clr     = ~clr_filt_n;
        next_q.loop_en = clr_filt_n;
        if (q.clr) begin
            next_q.resid = '0;
            next_q.err   = '0;
            next_q.delta = 2'sd0;
        end else begin
            next_q.resid = r;
            next_q.err   = e;
        end

        // Register writes; zero gear terms are outside the setting range
        if (i_wr) begin
            case (i_addr)
                prp_pkg::CTRL_OFS: begin
                    next_q.form   = i_wdata[prp_pkg::FORM_LSB +: 2];
                    next_q.mult   = i_wdata[prp_pkg::MULT_LSB +: 2];
                    next_q.ocf    = i_wdata[prp_pkg::OCF_BIT];
                    // RULE11: smoothing filter select
                    next_q.smooth = i_wdata[prp_pkg::SMOOTH_BIT];
                end
                prp_pkg::NUM_OFS: begin
                    if (i_wdata[15:0] != 16'h0000) begin
                        next_q.num = i_wdata[15:0];
                    end
                end
                prp_pkg::DEN_OFS: begin
                    if (i_wdata[15:0] != 16'h0000) begin
                        next_q.den = i_wdata[15:0];
                    end
                end
                default: next_q.num = next_q.num;
            endcase
        end

        // Read data live for exactly one cycle; unmapped reads return zero
        next_q.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                prp_pkg::CTRL_OFS: begin
                    next_q.rdata = 32'({q.smooth, q.ocf, q.mult, q.form});
                end
                prp_pkg::NUM_OFS: begin
                    next_q.rdata = {16'h0000, q.num};
                end
                prp_pkg::DEN_OFS: begin
                    next_q.rdata = {16'h0000, q.den};
                end
                prp_pkg::ERR_OFS: begin
                    next_q.rdata = 32'(signed'(q.err));
                end
                prp_pkg::STAT_OFS: begin
                    next_q.rdata[prp_pkg::STAT_CLR_BIT]  = q.clr;
                    next_q.rdata[prp_pkg::STAT_LOOP_BIT] = q.loop_en;
                end
                default: next_q.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q         <= '0;
            q.form    <= prp_pkg::CTRL_RST[prp_pkg::FORM_LSB +: 2];
            q.mult    <= prp_pkg::CTRL_RST[prp_pkg::MULT_LSB +: 2];
            q.ocf     <= prp_pkg::CTRL_RST[prp_pkg::OCF_BIT];
            q.smooth  <= prp_pkg::CTRL_RST[prp_pkg::SMOOTH_BIT];
            q.num     <= prp_pkg::NUM_RST;
            q.den     <= prp_pkg::DEN_RST;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register
    assign o_rdata        = q.rdata;
    assign o_err_count    = q.err;
    assign o_loop_enable  = q.loop_en;
    assign o_smooth_sel   = q.smooth;
    assign o_clear_active = q.clr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    a_step_fwd_count: assert property (q.form == prp_pkg::FORM_STEP && p_filt && !q.p_d && s_filt && !q.clr // RULE1
                                       |=> q.delta == 2'sd1 || q.clr)
        else $error("step form forward pulse not counted");
    a_step_every_pulse: assert property (q.form == prp_pkg::FORM_STEP && p_filt && !q.p_d && !q.clr // RULE2
                                         |=> q.delta != 2'sd0 || q.clr)
        else $error("step form pulse dropped");
    a_dual_rev_count: assert property (q.form == prp_pkg::FORM_DUAL && s_filt && !q.s_d // RULE3
                                       && !(p_filt && !q.p_d) && !q.clr |=> q.delta == -2'sd1 || q.clr)
        else $error("dual form reverse pulse not counted");
    a_quad_fwd_dir: assert property (q.form == prp_pkg::FORM_QUAD && p_filt && !q.p_d && s_filt // RULE4
                                     && s_filt == q.s_d && !q.clr |=> q.delta == 2'sd1 || q.clr)
        else $error("quadrature B leading A not forward");
    a_quad_x1_skip: assert property (q.form == prp_pkg::FORM_QUAD && q.mult == prp_pkg::MULT_X1 // RULE5
                                     && p_filt == q.p_d |=> q.delta == 2'sd0)
        else $error("x1 counted a non A edge");
    a_gear_unit_ratio: assert property (q.num == q.den && q.delta == 2'sd1 && q.resid == '0 && !i_fb_step // RULE9
                                        && !q.clr |=> q.err == $past(q.err) + ERR_W'(1) && q.resid == '0)
        else $error("unit gear ratio did not give one count");
    a_gear_settled: assert property (q.delta == 2'sd0 && !q.resid[RES_W-1] && q.resid < RES_W'(q.den) // RULE14
                                     && !i_fb_step && !q.clr |=> $stable(q.err) && $stable(q.resid))
        else $error("settled remainder moved the counter");
    a_smooth_select: assert property (i_wr && i_addr == prp_pkg::CTRL_OFS // RULE11
                                      |=> o_smooth_sel == $past(i_wdata[prp_pkg::SMOOTH_BIT]))
        else $error("smoothing select not taken from write");
    a_clear_zeroes: assert property (q.clr |-> !o_loop_enable ##1 q.err == '0 && q.resid == '0) // RULE12
        else $error("clear did not zero the error counter");

endmodule

// [prp_host_model.sv]
// Host controller model that issues reference pulse trains
module prp_host_model (
    input  wire logic i_sys_clk, // System clock
    output logic      o_pulse,   // Step, forward pulse or phase A
    output logic      o_sign     // Sign, reverse pulse or phase B
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lines idle low; the host drives them at all times
    initial begin
        o_pulse = 1'b0;
        o_sign  = 1'b0;
    end
    // rate from quarter period
    // Caller picks q within the rated rate, except the q of 2 train in t_filter that the filter must reject
    task automatic send(input logic [1:0] form, input logic fwd, input int n, input int q);
        logic [7:0] seq;
        seq = fwd ? 8'h78 : 8'hB4;
        for (int i = 0; i < n; i++) begin
            if (form == prp_pkg::FORM_QUAD) begin
                for (int k = 0; k < 4; k++) begin
                    {o_pulse, o_sign} <= seq[7-2*k -: 2];
                    repeat (q) @(posedge i_sys_clk);
                end
            end else begin
                if (form == prp_pkg::FORM_STEP) o_sign <= fwd;
                repeat (q) @(posedge i_sys_clk);
                if (form == prp_pkg::FORM_STEP || fwd) o_pulse <= 1'b1;
                else o_sign <= 1'b1;
                repeat (2 * q) @(posedge i_sys_clk);
                o_pulse <= 1'b0;
                if (form != prp_pkg::FORM_STEP) o_sign <= 1'b0;
                repeat (q) @(posedge i_sys_clk);
            end
        end
    endtask
endmodule

// [prp_pulse_ref_tb.sv]
// Self-checking bench for the pulse reference front end
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: diff", $time); end end
module prp_pulse_ref_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               i_sys_clk;
    logic               i_rst_n = 1'b0;
    logic               i_clear_req_n = 1'b1;
    logic               i_fb_step = 1'b0;
    logic               i_fb_dir = 1'b0;
    logic               i_wr = 1'b0;
    logic               i_rd = 1'b0;
    logic [7:0]         i_addr = 8'h00;
    logic [31:0]        i_wdata = 32'h0;
    logic [31:0]        o_rdata;
    logic signed [31:0] o_err_count;
    logic signed [31:0] exp_err = 32'h0;
    logic               o_loop_enable, o_smooth_sel, o_clear_active, ref_pulse, ref_sign;
    int                 fails = 0;
    int                 checked = 0;
    int                 qs[3] = '{5, 7, 13};
    prp_host_model u_host (.i_sys_clk(i_sys_clk), .o_pulse(ref_pulse), .o_sign(ref_sign));
    prp_pulse_ref u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ref_pulse(ref_pulse), .i_ref_sign(ref_sign),
        .i_clear_req_n(i_clear_req_n), .i_fb_step(i_fb_step), .i_fb_dir(i_fb_dir), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_err_count(o_err_count),
        .o_loop_enable(o_loop_enable), .o_smooth_sel(o_smooth_sel), .o_clear_active(o_clear_active));
    // 10 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    // --------------------------------
    // Bus and comparison helpers
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask
    // Long enough for sync, filter and gear division to settle
    task automatic err_by(input int d);
        repeat (40) @(posedge i_sys_clk);
        exp_err = exp_err + d;
        `CHK(o_err_count, exp_err)
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_regs();
        rd(prp_pkg::CTRL_OFS, 32'h0);
        rd(prp_pkg::STAT_OFS, 32'h2);
        wr(prp_pkg::NUM_OFS, 32'h0);
        wr(prp_pkg::ERR_OFS, 32'h5);
        rd(prp_pkg::NUM_OFS, 32'h1);
        rd(prp_pkg::DEN_OFS, 32'h1);
        #100 `CHK(o_rdata, 32'h0)
        rd(prp_pkg::ERR_OFS, 32'h0);
        rd(8'h14, 32'h0);
    endtask
    task automatic t_forms();
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 5, 5);
        err_by(5);
        u_host.send(prp_pkg::FORM_STEP, 1'b0, 3, 5);
        err_by(-3);
        wr(prp_pkg::CTRL_OFS, 32'h1);
        u_host.send(prp_pkg::FORM_DUAL, 1'b1, 4, 5);
        err_by(4);
        u_host.send(prp_pkg::FORM_DUAL, 1'b0, 6, 5);
        err_by(-6);
        for (int m = 0; m < 3; m++) begin
            wr(prp_pkg::CTRL_OFS, 32'h2 | (m << 2));
            u_host.send(prp_pkg::FORM_QUAD, 1'b1, 2, qs[m]);
            err_by(2 << m);
        end
        u_host.send(prp_pkg::FORM_QUAD, 1'b0, 1, 13);
        err_by(-4);
    endtask
    // Remainder must survive between pulses at 1/3
    task automatic t_gear();
        wr(prp_pkg::CTRL_OFS, 32'h0);
        // reduced gear terms, ratio in range
        wr(prp_pkg::NUM_OFS, 32'h3);
        wr(prp_pkg::DEN_OFS, 32'h2);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 2, 5);
        err_by(3);
        wr(prp_pkg::NUM_OFS, 32'h1);
        wr(prp_pkg::DEN_OFS, 32'h3);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 2, 5);
        err_by(0);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 1, 5);
        err_by(1);
        wr(prp_pkg::DEN_OFS, 32'h1);
        for (int i = 0; i < 3; i++) begin
            @(posedge i_sys_clk);
            {i_fb_step, i_fb_dir} <= {1'b1, i < 2};
            @(posedge i_sys_clk);
            i_fb_step <= 1'b0;
        end
        err_by(-1);
        rd(prp_pkg::ERR_OFS, exp_err);
    endtask
    task automatic t_filter();
        wr(prp_pkg::CTRL_OFS, 32'h10);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 3, 2);
        err_by(0);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 3, 13);
        err_by(3);
        wr(prp_pkg::CTRL_OFS, 32'h20);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 2, 5);
        err_by(2);
        `CHK(o_smooth_sel, 1'b1)
        wr(prp_pkg::CTRL_OFS, 32'h0);
        repeat (2) @(posedge i_sys_clk);
        `CHK(o_smooth_sel, 1'b0)
    endtask
    task automatic t_clear();
        @(posedge i_sys_clk);
        i_clear_req_n <= 1'b0;
        repeat (2100) @(posedge i_sys_clk);
        u_host.send(prp_pkg::FORM_STEP, 1'b1, 2, 5);
        `CHK({o_clear_active, o_loop_enable, o_err_count}, {2'b10, 32'h0})
        rd(prp_pkg::STAT_OFS, 32'h1);
        @(posedge i_sys_clk);
        i_clear_req_n <= 1'b1;
        exp_err = 32'h0;
        err_by(0);
        `CHK({o_clear_active, o_loop_enable}, 2'b01)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // registers first, pulses only once the drive is up
        t_regs();
        t_forms();
        t_gear();
        t_filter();
        t_clear();
        report_and_stop();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge i_sys_clk);
        fails++;
        report_and_stop();
    end
endmodule
